// ---- rtl/hss_consts.svh ----
`ifndef HSS_CONSTS_SVH
`define HSS_CONSTS_SVH

// Clock period in picoseconds (40 MHz).
`define CLK_PERIOD_PS       25000
// Blanking after enable, nominal, in microseconds.
`define BLANK_TIME_US       25
`define BLANK_CYCLES        ((`BLANK_TIME_US * 1000000) / `CLK_PERIOD_PS)
// Over-current trip time, nominal, in microseconds.
`define OC_TRIP_TIME_US     10
`define OC_TRIP_CYCLES      ((`OC_TRIP_TIME_US * 1000000) / `CLK_PERIOD_PS)
// Fault clear time, nominal, in microseconds.
`define FAULT_CLEAR_TIME_US 200
`define FAULT_CLEAR_CYCLES  ((`FAULT_CLEAR_TIME_US * 1000000) / `CLK_PERIOD_PS)
// Width shared by every timer.
`define TIMER_W             16
// Sense output codes.
`define SENSE_ZERO          2'h0
`define SENSE_LIVE          2'h1
`define SENSE_FULL          2'h2

`endif

// ---- rtl/hss_pkg.sv ----
package hss_pkg;

	// Host command inputs.
	typedef struct packed {
		logic enable;
		logic high_cmd;
		logic low_cmd;
		logic xcond_cfg;
	} host_cmd_t;

	// Comparator flags from the analog front end.
	typedef struct packed {
		logic supply_low;
		logic high_overtemp;
		logic low_overtemp;
		logic overcurrent;
		logic drain_overload;
		logic high_gate_below_thr;
	} sense_flags_t;

	// Analog output selection codes.
	typedef logic [1:0] sense_code_t;

	typedef enum logic [1:0] {
		MODE_SLEEP,
		MODE_BLANK,
		MODE_NORMAL
	} mode_t;

endpackage

// ---- rtl/hss_sync.sv ----
`timescale 1ns/1ps
`include "hss_consts.svh"

// Three-stage synchroniser; output changes when stages two and three agree.
module hss_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_next;

	// Only bits where the two late stages agree update the output.
	assign q_next = (q & ~(s2_reg ^ s3_reg)) ^ (q & (s2_reg ^ s3_reg)) ^ ((s2_reg ^ q) & ~(s2_reg ^ s3_reg));

	// The first stage is read by the second stage alone.
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q      <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q      <= q_next;
		end
	end

endmodule

// ---- rtl/high_side_switch_control.sv ----
`timescale 1ns/1ps
`include "hss_consts.svh"

// Summary of operation
// - Enable alone selects sleep (low) or normal (high) mode.
// - Sleep: outputs off, commands ignored, fault output held high.
// - After enable rises, commands are ignored for a blanking interval.
// - Blanking interval is 25 us nominal, within 10 to 50 us.
// - Configuration low: high and low side follow their commands independently.
// - Configuration high: never both on; high command wins.
// - Low gate rises after high command falls only once high gate is below threshold.
// - Under-voltage forces high output off until supply recovers.
// - Under-voltage clears every latched fault.
// - Fault output low throughout under-voltage, released at once, never latched.
// - Over-temperature is evaluated whenever enable is high, regardless of output state.
// - High side over-temperature turns output off, resumes when it clears.
// - Low side over-temperature turns both off until it clears, then resumes.
// - Fault release after low side over-temperature is delayed by blanking interval.
// - Any over-temperature forces temperature feedback to zero.
// - Over-current latches output off and sense output to zero.
// - Output switches off within over-current trip time of the trip.
// - Over-current trip time is 10 us nominal, within 1 to 20 us.
// - High command low for fault clear time clears over-current; sense full while low.
// - Fault clear time is 200 us nominal, within 100 to 400 us.
// - Low side overload detection is armed only while low command is high.
// - Drain overload latches low gate off and turns overload source off.
// - Low command low for fault clear time clears overload and re-enables drive.
// - Sleep turns off the bootstrap supply.
// - Fault output low on over-temperature, over-current, overload; latter two latched.
module high_side_switch_control
	import hss_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Host command pins
	input  host_cmd_t          cmd_in,
	// Analog comparator flags
	input  sense_flags_t       flags_in,
	// Power stage controls
	output logic               high_out_on,
	output logic               low_gate_drive,
	output logic               overload_level_pin,
	output logic               bootstrap_cap,
	// Host reporting
	output logic               fault_n,
	output logic               temp_zero,
	output sense_code_t        current_sense_out
);

	// Synchronised copies of the pins and flags.
	host_cmd_t    cmd;
	sense_flags_t flg;
	// Operating mode, its blanking timer, then the fault timers and latches.
	mode_t        mode_reg;
	mode_t        mode_next;
	logic [`TIMER_W-1:0] blank_cnt_reg;
	logic [`TIMER_W-1:0] blank_cnt_next;
	logic [`TIMER_W-1:0] hs_low_cnt_reg;
	logic [`TIMER_W-1:0] ls_low_cnt_reg;
	logic [`TIMER_W-1:0] oc_cnt_reg;
	logic [`TIMER_W-1:0] lot_cnt_reg;
	logic                oc_latch_reg;
	logic                ol_latch_reg;
	logic                lot_hold_reg;
	logic                lot_seen_reg;

	// Decoded conditions shared by the processes below.
	logic                out_idle;
	logic                blank_done;
	logic                hs_clear_met;
	logic                ls_clear_met;
	logic                oc_trip;
	logic                lot_done;
	logic                active;
	logic                any_overtemp;
	logic                oc_set;
	logic                ol_set;
	logic                hs_req;
	logic                ls_req;
	logic                hs_block;
	logic                high_drive;
	logic                ls_allowed;
	logic                low_drive;
	logic                fault_any;
	sense_code_t         cs_code;

	// Next values of the registered outputs.
	logic                high_out_next;
	logic                low_gate_next;
	logic                overload_src_next;
	logic                boot_supply_next;
	logic                fault_n_next;
	logic                temp_zero_next;
	sense_code_t         sense_next;

	// Synchronise command pins and comparator flags.
	hss_sync #(.W(4)) u_cmd_sync (
		.clk (clk),
		.rst (rst),
		.d   (cmd_in),
		.q   (cmd)
	);

	hss_sync #(.W(6)) u_flag_sync (
		.clk (clk),
		.rst (rst),
		.d   (flags_in),
		.q   (flg)
	);

	// Saturating increment used by every timer.
	// Saturation keeps a long low command from wrapping the count back below its limit.
	function automatic logic [`TIMER_W-1:0] sat_inc(input logic [`TIMER_W-1:0] v);
		sat_inc = (&v) ? v : v + `TIMER_W'(1);
	endfunction

	// True once a timer has counted up to its limit; shared by every timer compare.
	// A greater-or-equal compare still holds if a count ever passes its limit.
	function automatic logic reached(input logic [`TIMER_W-1:0] cnt, input logic [`TIMER_W-1:0] lim);
		reached = (cnt >= lim);
	endfunction

	// Timer end points; each compare but the trip is against a named count from the constants header.
	assign blank_done   = reached(blank_cnt_reg, `TIMER_W'(`BLANK_CYCLES));
	assign hs_clear_met = reached(hs_low_cnt_reg, `TIMER_W'(`FAULT_CLEAR_CYCLES));
	assign ls_clear_met = reached(ls_low_cnt_reg, `TIMER_W'(`FAULT_CLEAR_CYCLES));
	// The trip compares one short of the count because the latch adds a cycle of its own.
	assign oc_trip      = reached(oc_cnt_reg, `TIMER_W'(`OC_TRIP_CYCLES - 1));
	assign lot_done     = reached(lot_cnt_reg, `TIMER_W'(`BLANK_CYCLES));

	// Mode and temperature decodes.
	assign active       = (mode_reg == MODE_NORMAL);
	assign any_overtemp = flg.high_overtemp | flg.low_overtemp;

	// Mode selection from enable only; blanking counts after enable rises.
	always_comb begin
		mode_next      = mode_reg;
		blank_cnt_next = blank_cnt_reg;
		case (mode_reg)
			MODE_SLEEP: begin
				blank_cnt_next = '0;
				if (cmd.enable) begin
					mode_next = MODE_BLANK;
				end
			end
			MODE_BLANK: begin
				// Counting starts on the cycle after the synchronised enable rises.
				blank_cnt_next = sat_inc(blank_cnt_reg);
				if (!cmd.enable) begin
					mode_next = MODE_SLEEP;
				end else if (blank_done) begin
					mode_next = MODE_NORMAL;
				end
			end
			MODE_NORMAL: begin
				if (!cmd.enable) begin
					mode_next = MODE_SLEEP;
				end
			end
			default: begin
				mode_next = MODE_SLEEP;
			end
		endcase
	end

	// Mode register; reset lands in sleep so every output starts idle.
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_reg      <= MODE_SLEEP;
			blank_cnt_reg <= '0;
		end else begin
			mode_reg      <= mode_next;
			blank_cnt_reg <= blank_cnt_next;
		end
	end

	// Low-time counters for the fault clear; a rising command restarts them.
	// A short high pulse restarts the count, so a running PWM input never clears a latch.
	always_ff @(posedge clk) begin
		if (rst || !active || cmd.high_cmd) begin
			hs_low_cnt_reg <= '0;
		end else begin
			hs_low_cnt_reg <= sat_inc(hs_low_cnt_reg);
		end
	end

	// The low side count mirrors the high side one; each clear needs its own unbroken low time.
	always_ff @(posedge clk) begin
		if (rst || !active || cmd.low_cmd) begin
			ls_low_cnt_reg <= '0;
		end else begin
			ls_low_cnt_reg <= sat_inc(ls_low_cnt_reg);
		end
	end

	// Over-current is filtered so the trip always lands inside the trip time.
	// The count restarts whenever the switch is off, so only a continuous over-current trips it.
	always_ff @(posedge clk) begin
		if (rst || !flg.overcurrent || !high_drive) begin
			oc_cnt_reg <= '0;
		end else begin
			oc_cnt_reg <= sat_inc(oc_cnt_reg);
		end
	end

	// Latched faults; under-voltage and sleep clear them, a new trip wins over the timed clear.
	// Each set term needs live conditions; each clear term needs a full low time.
	assign oc_set = active && flg.overcurrent && high_drive && oc_trip;
	assign ol_set = active && cmd.low_cmd && flg.drain_overload;

	// Over-current latch: held until the high command has been low for the clear time.
	always_ff @(posedge clk) begin
		if (rst || flg.supply_low || !cmd.enable) begin
			oc_latch_reg <= 1'b0;
		end else begin
			oc_latch_reg <= oc_set | (oc_latch_reg & ~hs_clear_met);
		end
	end

	// Overload latch: the set term is ORed in so a trip in the clearing cycle still latches.
	always_ff @(posedge clk) begin
		if (rst || flg.supply_low || !cmd.enable) begin
			ol_latch_reg <= 1'b0;
		end else begin
			ol_latch_reg <= ol_set | (ol_latch_reg & ~ls_clear_met);
		end
	end

	// Fault report stays low for a blanking interval after low side over-temperature clears.
	// A fresh over-temperature restarts the hold, so back-to-back events stretch the report.
	// The hold gives the bootstrap capacitor time to recharge before the host drives again.
	always_ff @(posedge clk) begin
		if (rst || !cmd.enable) begin
			lot_seen_reg <= 1'b0;
			lot_hold_reg <= 1'b0;
			lot_cnt_reg  <= '0;
		end else if (flg.low_overtemp) begin
			lot_seen_reg <= 1'b1;
			lot_hold_reg <= 1'b1;
			lot_cnt_reg  <= '0;
		end else if (lot_seen_reg) begin
			lot_cnt_reg  <= sat_inc(lot_cnt_reg);
			if (lot_done) begin
				lot_seen_reg <= 1'b0;
				lot_hold_reg <= 1'b0;
			end
		end
	end

	// Command steering for both configurations.
	assign hs_req     = active && cmd.high_cmd;
	assign ls_req     = active && cmd.low_cmd;
	// Every condition that forces the high side off, latched or live.
	assign hs_block   = flg.supply_low | flg.high_overtemp | flg.low_overtemp | oc_latch_reg;
	assign high_drive = hs_req && !hs_block;
	// In cross-conduction mode the low gate waits on the high gate threshold comparator.
	// The registered switch state is checked too, so a slow comparator cannot overlap the sides.
	assign ls_allowed = cmd.xcond_cfg ? (!cmd.high_cmd && flg.high_gate_below_thr && !high_out_on)
	                                  : 1'b1;
	assign low_drive  = ls_req && ls_allowed && !flg.low_overtemp && !ol_latch_reg && !ol_set;
	// Under-voltage reports live; the latched faults and the over-temperature hold add to it.
	assign fault_any  = flg.supply_low | any_overtemp | lot_hold_reg | oc_latch_reg | ol_latch_reg;

	// Sense output: zero on latched over-current, full while high command is low.
	assign cs_code    = oc_latch_reg ? (cmd.high_cmd ? `SENSE_ZERO : `SENSE_FULL) : `SENSE_LIVE;

	// Next values of the outputs; sleep and reset are handled by the registers below.
	assign out_idle          = rst | ~cmd.enable;
	assign high_out_next     = high_drive;
	assign low_gate_next     = low_drive;
	assign overload_src_next = !ol_latch_reg && !ol_set;
	// The bootstrap supply runs in every enabled mode so the capacitor charges during blanking.
	assign boot_supply_next  = 1'b1;
	assign fault_n_next      = !fault_any;
	assign temp_zero_next    = any_overtemp;
	assign sense_next        = cs_code;

	// High side switch; the only path to on is through the steering above.
	// Sleep forces it off even while a command is still high.
	always_ff @(posedge clk) begin
		if (out_idle) begin
			high_out_on <= 1'b0;
		end else begin
			high_out_on <= high_out_next;
		end
	end

	// Low side gate drive.
	always_ff @(posedge clk) begin
		if (out_idle) begin
			low_gate_drive <= 1'b0;
		end else begin
			low_gate_drive <= low_gate_next;
		end
	end

	// Overload level current source.
	always_ff @(posedge clk) begin
		if (out_idle) begin
			overload_level_pin <= 1'b0;
		end else begin
			overload_level_pin <= overload_src_next;
		end
	end

	// Bootstrap supply; off in sleep to save current.
	always_ff @(posedge clk) begin
		if (out_idle) begin
			bootstrap_cap <= 1'b0;
		end else begin
			bootstrap_cap <= boot_supply_next;
		end
	end

	// Fault report, active low.
	// Sleep releases it, since the latches are cleared there as well.
	always_ff @(posedge clk) begin
		if (out_idle) begin
			fault_n <= 1'b1;
		end else begin
			fault_n <= fault_n_next;
		end
	end

	// Temperature feedback forcing.
	always_ff @(posedge clk) begin
		if (out_idle) begin
			temp_zero <= 1'b0;
		end else begin
			temp_zero <= temp_zero_next;
		end
	end

	// Current sense selection.
	// Idle shows the live reading, which reads near zero with the switch off.
	always_ff @(posedge clk) begin
		if (out_idle) begin
			current_sense_out <= `SENSE_LIVE;
		end else begin
			current_sense_out <= sense_next;
		end
	end

endmodule

// ---- dv/hss_monitor.sv ----
`timescale 1ns/1ps
`include "hss_consts.svh"

// Port checks; each antecedent on the input pins lasts past the synchroniser latency.
module hss_monitor
	import hss_pkg::*;
(
	// Clock, reset and inputs
	input  wire logic   clk,
	input  wire logic   rst,
	input  host_cmd_t   cmd_in,
	input  sense_flags_t flags_in,
	// Outputs watched
	input  wire logic   high_out_on,
	input  wire logic   low_gate_drive,
	input  wire logic   overload_level_pin,
	input  wire logic   bootstrap_cap,
	input  wire logic   fault_n,
	input  wire logic   temp_zero,
	input  sense_code_t current_sense_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [9:0] oc_cnt_reg;

	// Counts overcurrent cycles with the switch on; saturates so it cannot wrap.
	always_ff @(posedge clk) begin
		if (rst || !(flags_in.overcurrent && high_out_on))
			oc_cnt_reg <= 10'h0;
		else if (oc_cnt_reg != 10'h3ff)
			oc_cnt_reg <= oc_cnt_reg + 10'h1;
	end

	sequence s_sleep; !cmd_in.enable [*8]; endsequence
	sequence s_hot; ((flags_in.high_overtemp || flags_in.low_overtemp) && cmd_in.enable) [*8]; endsequence
	sequence s_ovl; (cmd_in.low_cmd && flags_in.drain_overload && cmd_in.enable) [*8]; endsequence

	property p_sleep; s_sleep |-> !high_out_on && !low_gate_drive && fault_n && !bootstrap_cap; endproperty
	property p_blank; $rose(bootstrap_cap) |-> !high_out_on [*8]; endproperty
	property p_xc; cmd_in.xcond_cfg [*8] |-> !(high_out_on && low_gate_drive); endproperty
	property p_uv; (flags_in.supply_low && cmd_in.enable) [*8] |-> !high_out_on && !fault_n; endproperty
	property p_hot; s_hot |-> temp_zero && !high_out_on && !fault_n; endproperty
	property p_lot; flags_in.low_overtemp [*8] |-> !low_gate_drive; endproperty
	property p_oc0; current_sense_out == `SENSE_ZERO |-> !high_out_on && !fault_n; endproperty
	property p_trip; oc_cnt_reg < 10'h1a4; endproperty
	property p_ovl; s_ovl |-> !low_gate_drive && !overload_level_pin && !fault_n; endproperty

	a_sleep: assert property (p_sleep) else $error("outputs active in sleep");
	a_blank: assert property (p_blank) else $error("switch on during blanking");
	a_xc: assert property (p_xc) else $error("both sides on");
	a_uv: assert property (p_uv) else $error("undervoltage not handled");
	a_hot: assert property (p_hot) else $error("overtemperature not handled");
	a_lot: assert property (p_lot) else $error("low gate on while hot");
	a_oc0: assert property (p_oc0) else $error("sense zero without trip");
	a_trip: assert property (p_trip) else $error("overcurrent trip too slow");
	a_ovl: assert property (p_ovl) else $error("overload not latched off");
endmodule

bind high_side_switch_control hss_monitor u_mon (.clk(clk), .rst(rst), .cmd_in(cmd_in), .flags_in(flags_in),
	.high_out_on(high_out_on), .low_gate_drive(low_gate_drive), .overload_level_pin(overload_level_pin),
	.bootstrap_cap(bootstrap_cap), .fault_n(fault_n), .temp_zero(temp_zero),
	.current_sense_out(current_sense_out));

// ---- dv/hss_front_model.sv ----
`timescale 1ns/1ps

// Analog front end; the gate flag lags turn-off while the gate bleeds down.
module hss_front_model
	import hss_pkg::*;
(
	// Clock and switch state
	input  wire logic   clk,
	input  wire logic   high_out_on,
	// Injected comparator levels and result
	input  sense_flags_t inj,
	output sense_flags_t flags
);
	logic [2:0] off_reg;

	// Three cycles of discharge before the gate reads below threshold.
	always_ff @(posedge clk) begin
		off_reg <= {off_reg[1:0], !high_out_on};
	end

	assign flags = {inj[5:1], &off_reg};
endmodule

// ---- dv/high_side_switch_control_bench.sv ----
`timescale 1ns/1ps
`include "hss_consts.svh"

module high_side_switch_control_bench import hss_pkg::*;;
	logic         clk, rst, hi, lo, olp, boot, fault_n, tz;
	host_cmd_t    cmd;
	sense_flags_t inj, flags;
	sense_code_t  cs;
	logic [3:0]   obs;
	int           error_cnt, total_checks, cyc;

	// Observed state packed as high, low, fault, overload source.
	assign obs = {hi, lo, fault_n, olp};

	high_side_switch_control dut (.clk(clk), .rst(rst), .cmd_in(cmd), .flags_in(flags), .high_out_on(hi),
		.low_gate_drive(lo), .overload_level_pin(olp), .bootstrap_cap(boot), .fault_n(fault_n),
		.temp_zero(tz), .current_sense_out(cs));
	hss_front_model front (.clk(clk), .high_out_on(hi), .inj(inj), .flags(flags));

	task automatic results();
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Inputs change only at the rising edge.
	task automatic drv(input logic [3:0] c, input logic [5:0] f);
		@(posedge clk);
		cmd <= c;
		inj <= f;
	endtask

	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard well above the longest sequence.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			$display("[ERR] %0t timeout", $time);
			results();
		end
	end

	initial begin
		rst = 1'b1;
		cmd = 4'h0;
		inj = 6'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		step(2);
		chk({2'h0, cs}, {2'h0, `SENSE_LIVE});
		drv(4'h6, 6'h0); step(20); chk({1'b0, obs[3:1]}, 4'h1); chk({3'h0, boot}, 4'h0);
		drv(4'hc, 6'h0); step(20); chk({3'h0, boot}, 4'h1); chk({1'b0, obs[3:1]}, 4'h1);
		step(500); chk({3'h0, hi}, 4'h0);
		step(800); chk(obs, 4'hb);
		for (int i = 0; i < 4; i++) begin
			drv({1'b1, i[1:0], 1'b0}, 6'h0); step(20); chk(obs, {i[1:0], 2'h3});
		end
		drv(4'hf, 6'h0); step(20); chk(obs, 4'hb);
		drv(4'hb, 6'h0);
		for (int k = 0; k < 50 && hi !== 1'b0; k++) step(1);
		chk(obs, 4'h3); step(20); chk(obs, 4'h7);
		drv(4'he, 6'h20); step(20); chk({2'h0, hi, fault_n}, 4'h0);
		drv(4'he, 6'h0); step(20); chk(obs, 4'hf);
		drv(4'he, 6'h10); step(20); chk(obs, 4'h5); chk({3'h0, tz}, 4'h1);
		drv(4'he, 6'h0); step(20); chk(obs, 4'hf);
		drv(4'he, 6'h08); step(20); chk(obs, 4'h1); chk({3'h0, tz}, 4'h1);
		drv(4'he, 6'h0); step(20); chk({3'h0, fault_n}, 4'h0);
		step(1100); chk(obs, 4'hf);
		drv(4'hc, 6'h04); step(30); chk({3'h0, hi}, 4'h1);
		for (int k = 0; k < 770 && hi !== 1'b0; k++) step(1);
		chk(obs, 4'h1); chk({2'h0, cs}, {2'h0, `SENSE_ZERO});
		drv(4'hc, 6'h0); step(100); chk(obs, 4'h1);
		drv(4'h8, 6'h0); step(20); chk({2'h0, cs}, {2'h0, `SENSE_FULL});
		step(2000); drv(4'hc, 6'h0); step(20); chk(obs, 4'h1);
		drv(4'h8, 6'h0); step(16100); drv(4'hc, 6'h0); step(20); chk(obs, 4'hb);
		drv(4'h8, 6'h02); step(20); chk(obs, 4'h3);
		drv(4'ha, 6'h02); step(20); chk(obs, 4'h0);
		drv(4'ha, 6'h0); step(20); chk(obs, 4'h0);
		drv(4'h8, 6'h0); step(16100); drv(4'ha, 6'h0); step(20); chk(obs, 4'h7);
		drv(4'ha, 6'h02); step(20); drv(4'ha, 6'h20); step(20); drv(4'ha, 6'h0); step(20);
		chk(obs, 4'h7);
		drv(4'h0, 6'h0); step(20); chk({1'b0, obs[3:1]}, 4'h1);
		results();
	end
endmodule
